// File: rsc_regs.vh
// Register offsets, field positions, reset values and timing counts for the reset source control block
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// ==========================================
// Register offsets (byte addresses)
`define RSC_ADDR_CAUSE 8'h00
`define RSC_ADDR_BOR_CTL 8'h04
`define RSC_ADDR_PERIPH_RST0 8'h08
`define RSC_ADDR_PERIPH_RST1 8'h0C
`define RSC_ADDR_PERIPH_RST2 8'h10
`define RSC_ADDR_CORE_CTL 8'h14
`define RSC_ADDR_WDOG_LOAD 8'h18
`define RSC_ADDR_WDOG_CTL 8'h1C
`define RSC_ADDR_WDOG_VALUE 8'h20
`define RSC_ADDR_REG_CTL 8'h24
`define RSC_ADDR_IDENT0 8'h28
`define RSC_ADDR_IDENT1 8'h2C
`define RSC_ADDR_CAP0 8'h30
`define RSC_ADDR_CAP1 8'h34
`define RSC_ADDR_CAP2 8'h38
`define RSC_ADDR_CAP3 8'h3C
`define RSC_ADDR_CAP4 8'h40

// ==========================================
// Reset-cause bit positions
`define RSC_CAUSE_EXT 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_BOR 2
`define RSC_CAUSE_WDOG 3
`define RSC_CAUSE_SW 4

// ==========================================
// Control bit positions
`define RSC_BOR_RST_EN_BIT 1
`define RSC_SYS_REQ_BIT 2
`define RSC_WDOG_INT_EN_BIT 0
`define RSC_WDOG_RST_EN_BIT 1
`define RSC_WDOG_INT_CLR_BIT 2

// ==========================================
// Reset values
`define RSC_WDOG_LOAD_RST 32'hFFFFFFFF
`define RSC_REG_ADJ_RST 8'h00
`define RSC_PERIPH_RST_VAL 32'h00000000

// ==========================================
// Identification (arbitrary neutral values)
`define RSC_IDENT0_VAL 32'h00010000
`define RSC_IDENT1_VAL 32'h10020000
`define RSC_CAP0_VAL 32'h00070007
`define RSC_CAP1_VAL 32'h00000000
`define RSC_CAP2_VAL 32'h00000000
`define RSC_CAP3_VAL 32'h00000000
`define RSC_CAP4_VAL 32'h00000000

// ==========================================
// Timing
`define RSC_CLK_PERIOD_PS 5000
`define RSC_HOLD_TIME_NS 100
`define RSC_HOLD_CYCLES ((`RSC_HOLD_TIME_NS * 1000 + `RSC_CLK_PERIOD_PS - 1) / `RSC_CLK_PERIOD_PS)

`endif

// File: rsc_reset_ctrl.v
// Reset source control: merges reset sources, reset-cause flags, watchdog and boot fetch sequence
//
// Summary of operation
// - Reset requests come from pin, power-on, brown-out, software and watchdog.
// - Power-on resets core, peripherals and the debug test controller.
// - Pin reset resets core and peripherals, not the debug test controller.
// - Brown-out reset acts as pin reset, held while supply stays low.
// - Brown-out reset disabled after reset until software sets enable bit.
// - Brown-out raises interrupt, or reset only when enable bit set.
// - Per-peripheral soft reset bit set then cleared resets that peripheral only.
// - Soft reset bit order matches peripheral clock-gating bit order.
// - Soft reset asserts every domain reset of the selected unit.
// - System reset request resets core and peripherals, not debug controller.
// - After release core fetches stack pointer, program counter, first instruction.
// - Each reset sets its cause flag; flags stick across later resets.
// - Power-on clears all other cause flags, leaving only power-on.
// - Power-on reset waits for detector to go inactive first.
// - Watchdog first time-out raises interrupt and reloads 32-bit counter.
// - Watchdog second zero with interrupt pending and reset enabled resets system.
// - Software regulator-adjust field sets regulator target in small steps.
// - Read-only identification and capability registers report part features.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "rsc_regs.vh"

module rsc_reset_ctrl
(
    input wire clk_sys_in,
    input wire sys_rst_in,
    input wire reset_pin_n_in,
    input wire power_on_detect_in,
    input wire brown_out_detect_in,
    input wire [7:0] bus_addr_in,
    input wire [31:0] bus_wdata_in,
    input wire bus_write_in,
    input wire bus_read_in,
    input wire fetch_done_in,
    output reg [31:0] bus_rdata_out,
    output wire core_rst_out,
    output wire debug_rst_out,
    output wire [95:0] periph_rst_out,
    output wire brown_out_int_out,
    output wire wdog_int_out,
    output wire [1:0] fetch_step_out,
    output wire fetch_req_out,
    output wire core_run_out,
    output wire [7:0] regulator_adjust_out
);

    // ==========================================
    // Boot sequence states
    localparam ST_RESET = 3'h0;
    localparam ST_HOLD = 3'h1;
    localparam ST_FETCH_SP = 3'h2;
    localparam ST_FETCH_PC = 3'h3;
    localparam ST_FETCH_INSTR = 3'h4;
    localparam ST_RUN = 3'h5;
    localparam [31:0] HOLD_FULL = `RSC_HOLD_CYCLES;
    // Count fits eight bits, upper bits dropped on purpose
    localparam [7:0] HOLD_CNT = HOLD_FULL[7:0];

    // ==========================================
    // Input synchronisers (three stages, second and third agree)
    reg [2:0] pin_sync_ff;
    reg [2:0] por_sync_ff;
    reg [2:0] bor_sync_ff;
    reg pin_low_ff;
    reg por_act_ff;
    reg bor_act_ff;

    always @(posedge clk_sys_in)
    begin
        pin_sync_ff <= {pin_sync_ff[1:0], reset_pin_n_in};
        por_sync_ff <= {por_sync_ff[1:0], power_on_detect_in};
        bor_sync_ff <= {bor_sync_ff[1:0], brown_out_detect_in};
        if (pin_sync_ff[1] == pin_sync_ff[2])
        begin
            pin_low_ff <= ~pin_sync_ff[2];
        end
        if (por_sync_ff[1] == por_sync_ff[2])
        begin
            por_act_ff <= por_sync_ff[2];
        end
        if (bor_sync_ff[1] == bor_sync_ff[2])
        begin
            bor_act_ff <= bor_sync_ff[2];
        end
    end

    // ==========================================
    // Registers
    reg por_seen_ff;
    reg [4:0] cause_ff;
    reg bor_rst_en_ff;
    reg bor_int_ff;
    reg [31:0] periph_soft_ff [0:2];
    reg sys_req_ff;
    reg [31:0] wdog_load_ff;
    reg [31:0] wdog_cnt_ff;
    reg wdog_int_en_ff;
    reg wdog_rst_en_ff;
    reg wdog_int_ff;
    reg wdog_fire_ff;
    reg [7:0] reg_adj_ff;
    reg [2:0] state_ff;
    reg [7:0] hold_cnt_ff;
    reg core_rst_ff;
    reg debug_rst_ff;
    reg [95:0] periph_rst_ff;

    // Power-on is the internal POR detector, or the first cycle after sys reset
    wire por_req = por_act_ff | ~por_seen_ff;
    wire bor_req = bor_act_ff & bor_rst_en_ff;
    wire sys_rst_req = por_req | pin_low_ff | bor_req | sys_req_ff | wdog_fire_ff;

    function is_write;
        input [7:0] addr;
        begin
            is_write = bus_write_in && (bus_addr_in == addr);
        end
    endfunction

    wire wdog_clr = is_write(`RSC_ADDR_WDOG_CTL) & bus_wdata_in[`RSC_WDOG_INT_CLR_BIT];
    wire wdog_zero = (wdog_cnt_ff == 32'h00000000);

    // ==========================================
    // Cause flags and power-on bookkeeping
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            por_seen_ff <= 1'b0;
            cause_ff <= 5'h00;
        end
        else
        begin
            por_seen_ff <= 1'b1;
            if (por_req)
            begin
                cause_ff <= 5'h01 << `RSC_CAUSE_POR;
            end
            else
            begin
                // sticky causes, set wins over clear
                cause_ff <= (is_write(`RSC_ADDR_CAUSE) ? (cause_ff & bus_wdata_in[4:0]) : cause_ff)
                    | {sys_req_ff, wdog_fire_ff, bor_req, 1'b0, pin_low_ff};
            end
        end
    end

    // ==========================================
    // Software-written controls
    integer i;
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            bor_rst_en_ff <= 1'b0;
            bor_int_ff <= 1'b0;
            sys_req_ff <= 1'b0;
            reg_adj_ff <= `RSC_REG_ADJ_RST;
            wdog_load_ff <= `RSC_WDOG_LOAD_RST;
            wdog_int_en_ff <= 1'b0;
            wdog_rst_en_ff <= 1'b0;
            for (i = 0; i < 3; i = i + 1)
            begin
                periph_soft_ff[i] <= `RSC_PERIPH_RST_VAL;
            end
        end
        else
        begin
            // request is a one-shot, high for the one cycle after the write strobe and cleared on the next
            sys_req_ff <= is_write(`RSC_ADDR_CORE_CTL) & bus_wdata_in[`RSC_SYS_REQ_BIT];
            if (core_rst_ff)
            begin
                // enable bit cleared by any system reset
                // kept while supply low, else reset would end early
                if (!bor_act_ff)
                begin
                    bor_rst_en_ff <= 1'b0;
                end
                wdog_int_en_ff <= 1'b0;
                wdog_rst_en_ff <= 1'b0;
                for (i = 0; i < 3; i = i + 1)
                begin
                    periph_soft_ff[i] <= `RSC_PERIPH_RST_VAL;
                end
            end
            else
            begin
                if (is_write(`RSC_ADDR_BOR_CTL))
                begin
                    bor_rst_en_ff <= bus_wdata_in[`RSC_BOR_RST_EN_BIT];
                end
                if (is_write(`RSC_ADDR_WDOG_CTL))
                begin
                    wdog_int_en_ff <= bus_wdata_in[`RSC_WDOG_INT_EN_BIT];
                    wdog_rst_en_ff <= bus_wdata_in[`RSC_WDOG_RST_EN_BIT];
                end
                if (is_write(`RSC_ADDR_PERIPH_RST0))
                begin
                    periph_soft_ff[0] <= bus_wdata_in;
                end
                if (is_write(`RSC_ADDR_PERIPH_RST1))
                begin
                    periph_soft_ff[1] <= bus_wdata_in;
                end
                if (is_write(`RSC_ADDR_PERIPH_RST2))
                begin
                    periph_soft_ff[2] <= bus_wdata_in;
                end
            end
            if (is_write(`RSC_ADDR_WDOG_LOAD))
            begin
                wdog_load_ff <= bus_wdata_in;
            end
            if (is_write(`RSC_ADDR_REG_CTL))
            begin
                reg_adj_ff <= bus_wdata_in[7:0];
            end
            // interrupt when reset disabled; set wins over clear
            if (bor_act_ff & ~bor_rst_en_ff)
            begin
                bor_int_ff <= 1'b1;
            end
            else if (is_write(`RSC_ADDR_BOR_CTL) & bus_wdata_in[0])
            begin
                bor_int_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Watchdog
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            wdog_cnt_ff <= `RSC_WDOG_LOAD_RST;
            wdog_int_ff <= 1'b0;
            wdog_fire_ff <= 1'b0;
        end
        else if (core_rst_ff)
        begin
            wdog_cnt_ff <= wdog_load_ff;
            wdog_int_ff <= 1'b0;
            wdog_fire_ff <= 1'b0;
        end
        else
        begin
            wdog_fire_ff <= 1'b0;
            if (is_write(`RSC_ADDR_WDOG_LOAD))
            begin
                wdog_cnt_ff <= bus_wdata_in;
            end
            else if (wdog_int_en_ff)
            begin
                if (wdog_zero)
                begin
                    wdog_cnt_ff <= wdog_load_ff;
                end
                else
                begin
                    wdog_cnt_ff <= wdog_cnt_ff - 32'h00000001;
                end
            end
            if (wdog_int_en_ff & wdog_zero & ~is_write(`RSC_ADDR_WDOG_LOAD))
            begin
                wdog_int_ff <= 1'b1;
                if (wdog_int_ff & wdog_rst_en_ff)
                begin
                    wdog_fire_ff <= 1'b1;
                end
            end
            else if (wdog_clr)
            begin
                wdog_int_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Reset release and boot fetch sequence
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= ST_RESET;
            hold_cnt_ff <= 8'h00;
            core_rst_ff <= 1'b1;
            debug_rst_ff <= 1'b1;
        end
        else
        begin
            debug_rst_ff <= por_req;
            case (state_ff)
                ST_RESET:
                begin
                    core_rst_ff <= 1'b1;
                    hold_cnt_ff <= 8'h00;
                    // wait for detector inactive; held while low supply
                    if (!sys_rst_req)
                    begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (sys_rst_req)
                    begin
                        state_ff <= ST_RESET;
                    end
                    else if (hold_cnt_ff == HOLD_CNT - 8'h01)
                    begin
                        core_rst_ff <= 1'b0;
                        state_ff <= ST_FETCH_SP;
                    end
                    else
                    begin
                        hold_cnt_ff <= hold_cnt_ff + 8'h01;
                    end
                end
                ST_FETCH_SP:
                begin
                    if (sys_rst_req)
                    begin
                        state_ff <= ST_RESET;
                        core_rst_ff <= 1'b1;
                    end
                    else if (fetch_done_in)
                    begin
                        state_ff <= ST_FETCH_PC;
                    end
                end
                ST_FETCH_PC:
                begin
                    if (sys_rst_req)
                    begin
                        state_ff <= ST_RESET;
                        core_rst_ff <= 1'b1;
                    end
                    else if (fetch_done_in)
                    begin
                        state_ff <= ST_FETCH_INSTR;
                    end
                end
                ST_FETCH_INSTR:
                begin
                    if (sys_rst_req)
                    begin
                        state_ff <= ST_RESET;
                        core_rst_ff <= 1'b1;
                    end
                    else if (fetch_done_in)
                    begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (sys_rst_req)
                    begin
                        state_ff <= ST_RESET;
                        core_rst_ff <= 1'b1;
                    end
                end
                default:
                begin
                    state_ff <= ST_RESET;
                    core_rst_ff <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================
    // Peripheral resets
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            periph_rst_ff <= {96{1'b1}};
        end
        else
        begin
            // soft bit covers all unit domains
            periph_rst_ff <= {96{sys_rst_req | core_rst_ff}}
                | {periph_soft_ff[2], periph_soft_ff[1], periph_soft_ff[0]};
        end
    end

    // ==========================================
    // Register read port
    always @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            bus_rdata_out <= 32'h00000000;
        end
        else if (bus_read_in)
        begin
            case (bus_addr_in)
                `RSC_ADDR_CAUSE: bus_rdata_out <= {27'h0000000, cause_ff};
                `RSC_ADDR_BOR_CTL: bus_rdata_out <= {29'h00000000, bor_act_ff, bor_rst_en_ff, bor_int_ff};
                `RSC_ADDR_PERIPH_RST0: bus_rdata_out <= periph_soft_ff[0];
                `RSC_ADDR_PERIPH_RST1: bus_rdata_out <= periph_soft_ff[1];
                `RSC_ADDR_PERIPH_RST2: bus_rdata_out <= periph_soft_ff[2];
                `RSC_ADDR_WDOG_LOAD: bus_rdata_out <= wdog_load_ff;
                `RSC_ADDR_WDOG_CTL: bus_rdata_out <= {29'h00000000, wdog_int_ff, wdog_rst_en_ff, wdog_int_en_ff};
                `RSC_ADDR_WDOG_VALUE: bus_rdata_out <= wdog_cnt_ff;
                `RSC_ADDR_REG_CTL: bus_rdata_out <= {24'h000000, reg_adj_ff};
                `RSC_ADDR_IDENT0: bus_rdata_out <= `RSC_IDENT0_VAL;
                `RSC_ADDR_IDENT1: bus_rdata_out <= `RSC_IDENT1_VAL;
                `RSC_ADDR_CAP0: bus_rdata_out <= `RSC_CAP0_VAL;
                `RSC_ADDR_CAP1: bus_rdata_out <= `RSC_CAP1_VAL;
                `RSC_ADDR_CAP2: bus_rdata_out <= `RSC_CAP2_VAL;
                `RSC_ADDR_CAP3: bus_rdata_out <= `RSC_CAP3_VAL;
                `RSC_ADDR_CAP4: bus_rdata_out <= `RSC_CAP4_VAL;
                default: bus_rdata_out <= 32'h00000000;
            endcase
        end
    end

    assign core_rst_out = core_rst_ff;
    assign debug_rst_out = debug_rst_ff;
    assign periph_rst_out = periph_rst_ff;
    assign brown_out_int_out = bor_int_ff;
    assign wdog_int_out = wdog_int_ff;
    assign fetch_req_out = (state_ff == ST_FETCH_SP) | (state_ff == ST_FETCH_PC) | (state_ff == ST_FETCH_INSTR);
    assign fetch_step_out = (state_ff == ST_FETCH_PC) ? 2'h1 : ((state_ff == ST_FETCH_INSTR) ? 2'h2 : 2'h0);
    assign core_run_out = (state_ff == ST_RUN);
    assign regulator_adjust_out = reg_adj_ff;

endmodule // rsc_reset_ctrl

// File: rsc_reset_monitor.sv
// Port-level assertions for the reset source control block
`timescale 1ns/1ps
`include "rsc_regs.vh"

module rsc_reset_monitor
(
    input wire clk_sys_in,
    input wire sys_rst_in,
    input wire reset_pin_n_in,
    input wire power_on_detect_in,
    input wire brown_out_detect_in,
    input wire [7:0] bus_addr_in,
    input wire [31:0] bus_wdata_in,
    input wire bus_write_in,
    input wire bus_read_in,
    input wire fetch_done_in,
    input wire [31:0] bus_rdata_out,
    input wire core_rst_out,
    input wire debug_rst_out,
    input wire [95:0] periph_rst_out,
    input wire brown_out_int_out,
    input wire wdog_int_out,
    input wire [1:0] fetch_step_out,
    input wire fetch_req_out,
    input wire core_run_out,
    input wire [7:0] regulator_adjust_out
);
    // Recent power-on history, covers the synchroniser latency
    reg [7:0] por_hist_ff;
    always @(posedge clk_sys_in)
    begin
        por_hist_ff <= {por_hist_ff[6:0], power_on_detect_in};
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    // ==========
    // Reset routing
    // full reset state
    AST_SYS_RST_ALL: assert property (disable iff (1'b0)
        sys_rst_in |=> core_rst_out && debug_rst_out && (&periph_rst_out)) else $error("reset state incomplete");
    AST_PERIPH_FOLLOWS: assert property (disable iff (sys_rst_in)
        $rose(core_rst_out) |=> (&periph_rst_out)) else $error("peripherals not reset with core");
    AST_DEBUG_ONLY_POR: assert property (disable iff (sys_rst_in)
        $rose(debug_rst_out) |-> (|por_hist_ff)) else $error("debug reset without power-on");
    AST_RELEASE_HOLD: assert property (disable iff (sys_rst_in)
        $fell(core_rst_out) |-> $past(reset_pin_n_in, 20) && !$past(power_on_detect_in, 20))
        else $error("core released too early");
    // ==========
    // Boot fetch sequence
    // fetch starts
    AST_FETCH_START: assert property (disable iff (sys_rst_in)
        $fell(core_rst_out) |-> fetch_req_out && fetch_step_out == 2'h0 && !core_run_out)
        else $error("fetch does not start at stack pointer");
    AST_FETCH_STEP: assert property (disable iff (sys_rst_in)
        fetch_req_out && fetch_done_in && fetch_step_out != 2'h2
        |=> fetch_req_out && fetch_step_out == $past(fetch_step_out) + 2'h1) else $error("fetch step out of order");
    AST_FETCH_RUN: assert property (disable iff (sys_rst_in)
        fetch_req_out && fetch_done_in && fetch_step_out == 2'h2 |=> core_run_out && !fetch_req_out)
        else $error("core not running after fetch");
    AST_NO_RUN_IN_RST: assert property (disable iff (sys_rst_in)
        core_rst_out && $past(core_rst_out) |-> !core_run_out && !fetch_req_out)
        else $error("core active while in reset");
    // ==========
    // Registers
    // ident read
    AST_READ_IDENT: assert property (disable iff (sys_rst_in)
        bus_read_in && bus_addr_in == `RSC_ADDR_IDENT0 |=> bus_rdata_out == `RSC_IDENT0_VAL)
        else $error("ident word wrong");
    AST_ADJ_WRITE: assert property (disable iff (sys_rst_in)
        bus_write_in && bus_addr_in == `RSC_ADDR_REG_CTL |=> regulator_adjust_out == $past(bus_wdata_in[7:0]))
        else $error("regulator adjust not updated");
    AST_BOR_INT_NO_RST: assert property (disable iff (sys_rst_in)
        $rose(brown_out_int_out) |-> !core_rst_out) else $error("brown-out interrupt beside reset");
endmodule // rsc_reset_monitor

bind rsc_reset_ctrl rsc_reset_monitor rsc_reset_monitor_inst (.clk_sys_in, .sys_rst_in, .reset_pin_n_in,
    .power_on_detect_in, .brown_out_detect_in, .bus_addr_in, .bus_wdata_in, .bus_write_in, .bus_read_in,
    .fetch_done_in, .bus_rdata_out, .core_rst_out, .debug_rst_out, .periph_rst_out, .brown_out_int_out,
    .wdog_int_out, .fetch_step_out, .fetch_req_out, .core_run_out, .regulator_adjust_out);

// File: rsc_far_model.sv
// Far-side model: reset pin, supply monitors and boot-fetch responder
`timescale 1ns/1ps

module rsc_far_model
#(
    parameter MIN_LOW = 8
)
(
    input wire clk_sys_in,
    input wire fetch_req_in,
    output reg reset_pin_n_out = 1'b1,
    output reg power_on_detect_out = 1'b0,
    output reg brown_out_detect_out = 1'b0,
    output reg fetch_done_out = 1'b0
);
    integer dly = 0;

    // ==========
    // Source pulses: 0 pin, 1 power-on, 2 brown-out
    task pulse(input integer sel, input integer c);
    begin
        @(posedge clk_sys_in);
        case (sel)
            0: reset_pin_n_out <= 1'b0;
            1: power_on_detect_out <= 1'b1;
            default: brown_out_detect_out <= 1'b1;
        endcase
        repeat ((c < MIN_LOW) ? MIN_LOW : c) @(posedge clk_sys_in);
        reset_pin_n_out <= 1'b1;
        power_on_detect_out <= 1'b0;
        brown_out_detect_out <= 1'b0;
    end
    endtask

    // ==========
    // Core fetch ack, random latency so slow and prompt answers both occur
    always @(posedge clk_sys_in)
    begin
        fetch_done_out <= 1'b0;
        if (fetch_req_in && !fetch_done_out)
        begin
            if (dly == 0)
            begin
                fetch_done_out <= 1'b1;
                dly <= $urandom_range(3, 0);
            end
            else
                dly <= dly - 1;
        end
    end
endmodule // rsc_far_model

// File: tb.sv
// Self-checking bench for the reset source control block
`timescale 1ns/1ps
`include "rsc_regs.vh"

module tb;
    reg clk_sys_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [7:0] bus_addr = 8'h00;
    reg [31:0] bus_wdata = 32'h00000000;
    reg bus_write = 1'b0;
    reg bus_read = 1'b0;
    reg rd_pend = 1'b0;
    wire pin_n, por, bor, fetch_done, core_rst, debug_rst, bo_int, wd_int, fetch_req, core_run;
    wire [31:0] rdata;
    wire [95:0] periph_rst;
    wire [1:0] fetch_step;
    wire [7:0] reg_adj;
    logic [31:0] exp_q [$];
    integer failures = 0;
    integer n_checks = 0;
    integer k;
    integer n;
    reg [7:0] a;
    reg [31:0] v;

    always #2.5 clk_sys_in = ~clk_sys_in;

    rsc_reset_ctrl rsc_reset_ctrl_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reset_pin_n_in(pin_n),
        .power_on_detect_in(por), .brown_out_detect_in(bor), .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata),
        .bus_write_in(bus_write), .bus_read_in(bus_read), .fetch_done_in(fetch_done), .bus_rdata_out(rdata),
        .core_rst_out(core_rst), .debug_rst_out(debug_rst), .periph_rst_out(periph_rst),
        .brown_out_int_out(bo_int), .wdog_int_out(wd_int), .fetch_step_out(fetch_step),
        .fetch_req_out(fetch_req), .core_run_out(core_run), .regulator_adjust_out(reg_adj));
    rsc_far_model rsc_far_model_inst (.clk_sys_in(clk_sys_in), .fetch_req_in(fetch_req),
        .reset_pin_n_out(pin_n), .power_on_detect_out(por), .brown_out_detect_out(bor),
        .fetch_done_out(fetch_done));

    // ==========
    // Compare and bus tasks
    task chk(input [95:0] g, input [95:0] e);
    begin
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task tick(input integer c);
    begin
        repeat (c) @(posedge clk_sys_in);
        #1;
    end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
    begin
        @(posedge clk_sys_in);
        bus_addr <= ad;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clk_sys_in);
        bus_write <= 1'b0;
    end
    endtask
    task rd(input [7:0] ad, input [31:0] e);
    begin
        exp_q.push_back(e);
        @(posedge clk_sys_in);
        bus_addr <= ad;
        bus_read <= 1'b1;
        @(posedge clk_sys_in);
        bus_read <= 1'b0;
    end
    endtask
    // Bounded wait: 0 core running, 1 watchdog interrupt, 2 core reset
    task wait_sig(input integer s);
        integer i;
        reg hit;
    begin
        hit = 1'b0;
        for (i = 0; i < 400 && !hit; i = i + 1)
        begin
            tick(1);
            hit = (s == 0) ? core_run === 1'b1 : (s == 1) ? wd_int === 1'b1 : core_rst === 1'b1;
        end
        chk(hit, 1'b1);
    end
    endtask
    task wrap_up;
    begin
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // Read data stands from the cycle after the strobe until the next read
    always @(posedge clk_sys_in)
    begin
        if (rd_pend)
            chk(rdata, exp_q.pop_front());
        rd_pend <= bus_read;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        failures = failures + 1;
        wrap_up;
    end

    // ==========
    // Main sequence
    initial
    begin
        void'($urandom(92));
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd(`RSC_ADDR_CAUSE, 32'h00000002);
        wr(`RSC_ADDR_IDENT0, 32'hFFFFFFFF);
        rd(`RSC_ADDR_IDENT0, `RSC_IDENT0_VAL);
        rd(`RSC_ADDR_IDENT1, `RSC_IDENT1_VAL);
        rd(`RSC_ADDR_CAP0, `RSC_CAP0_VAL);
        rd(8'h44, 32'h00000000);
        wait_sig(0);
        v = $urandom;
        wr(`RSC_ADDR_REG_CTL, v);
        rd(`RSC_ADDR_REG_CTL, {24'h000000, v[7:0]});
        tick(1);
        chk(reg_adj, v[7:0]);
        a = `RSC_ADDR_PERIPH_RST0;
        for (k = 0; k < 3; k = k + 1)
        begin
            n = $urandom_range(31, 0);
            v = 32'h00000001 << n;
            wr(a, v);
            tick(2);
            chk(periph_rst, {64'h0, v} << (32 * k));
            chk(core_rst, 1'b0);
            rd(a, v);
            wr(a, 32'h00000000);
            tick(2);
            chk(periph_rst, 96'h0);
            a = a + 8'h04;
        end
        rsc_far_model_inst.pulse(2, 10);
        tick(4);
        chk(bo_int, 1'b1);
        chk(core_rst, 1'b0);
        rd(`RSC_ADDR_BOR_CTL, 32'h00000001);
        wr(`RSC_ADDR_BOR_CTL, 32'h00000001);
        rd(`RSC_ADDR_BOR_CTL, 32'h00000000);
        wr(`RSC_ADDR_BOR_CTL, 32'h00000002);
        rd(`RSC_ADDR_BOR_CTL, 32'h00000002);
        fork
            rsc_far_model_inst.pulse(2, 40);
            begin
                tick(35);
                chk(core_rst, 1'b1);
            end
        join
        wait_sig(0);
        rd(`RSC_ADDR_CAUSE, 32'h00000006);
        wr(`RSC_ADDR_CORE_CTL, 32'h00000004);
        tick(3);
        chk(core_rst, 1'b1);
        chk(debug_rst, 1'b0);
        wait_sig(0);
        rd(`RSC_ADDR_CAUSE, 32'h00000016);
        fork
            rsc_far_model_inst.pulse(0, 30);
            begin
                tick(12);
                chk(core_rst, 1'b1);
                chk(debug_rst, 1'b0);
            end
        join
        wait_sig(0);
        rd(`RSC_ADDR_CAUSE, 32'h00000017);
        wr(`RSC_ADDR_WDOG_LOAD, 32'h00000032);
        wr(`RSC_ADDR_WDOG_CTL, 32'h00000003);
        wait_sig(1);
        chk(core_rst, 1'b0);
        wait_sig(2);
        wait_sig(0);
        rd(`RSC_ADDR_CAUSE, 32'h0000001F);
        wr(`RSC_ADDR_CAUSE, 32'h0000001D);
        rd(`RSC_ADDR_CAUSE, 32'h0000001D);
        fork
            rsc_far_model_inst.pulse(1, 30);
            begin
                tick(12);
                chk(debug_rst, 1'b1);
                chk(core_rst, 1'b1);
            end
        join
        wait_sig(0);
        rd(`RSC_ADDR_CAUSE, 32'h00000002);
        tick(3);
        wrap_up;
    end
endmodule // tb
